// File: fcp_defines.svh
/*
  Constants of the flash command host: register offsets, status bit positions,
  device command codes and addresses, and bus timing counts.
  Assumes a 50 MHz clock and a byte-wide flash with an 18-bit address.
*/
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// register offsets, low address byte of the AHB-Lite slave
`define FCP_REG_CTRL   8'h00
`define FCP_REG_ADDR   8'h04
`define FCP_REG_WDATA  8'h08
`define FCP_REG_STATUS 8'h0C
`define FCP_REG_RDATA  8'h10

// status register bit positions
`define FCP_ST_BUSY     0
`define FCP_ST_DONE     1
`define FCP_ST_REFUSED  2
`define FCP_ST_ID_MODE  3
`define FCP_ST_POLLFAIL 4

// flash geometry and data bus bit positions
`define FCP_ADDR_W   18
`define FCP_DATA_W   8
`define FCP_DQ_POLL  7
`define FCP_DQ_TOGGLE 6

// command addresses and codes
`define FCP_UNLOCK_A1   18'h05555
`define FCP_UNLOCK_A2   18'h02AAA
`define FCP_PROT_ADDR   18'h00002
`define FCP_CODE_AA     8'hAA
`define FCP_CODE_55     8'h55
`define FCP_CODE_PROG   8'hA0
`define FCP_CODE_ERASE  8'h80
`define FCP_CODE_PAGE   8'h30
`define FCP_CODE_CHIP   8'h10
`define FCP_CODE_ID     8'h90
`define FCP_CODE_RESET  8'hF0

// timing, in ns, and derived cycle counts (least times round up)
`define FCP_CLK_NS   20
`define FCP_WP_NS    50
`define FCP_ACC_NS   120
`define FCP_REC_NS   50
`define FCP_WP_CYC   ((`FCP_WP_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_ACC_CYC  ((`FCP_ACC_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_REC_CYC  ((`FCP_REC_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)

`endif

// File: fcp_pkg.sv
/*
  Types of the flash command host: operations, bus cycle kinds, the cycle
  request and the flash pin bundle.
  Assumes fcp_defines.svh is on the include path.
*/
`include "fcp_defines.svh"

package fcp_pkg;

  // operations software can order through the control register
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_PROGRAM    = 4'h1,
    OP_PAGE_ERASE = 4'h2,
    OP_CHIP_ERASE = 4'h3,
    OP_ID_ENTER   = 4'h4,
    OP_RESET      = 4'h5,
    OP_PROT_ON    = 4'h6,
    OP_PROT_OFF   = 4'h7,
    OP_PROT_HWCHK = 4'h8,
    OP_PROT_SWCHK = 4'h9,
    OP_HW_ID_READ = 4'hA
  } fcp_op_t;

  // single pin cycles the cycle engine can run
  typedef enum logic [2:0] {
    K_WRITE   = 3'b000,
    K_READ    = 3'b001,
    K_HV_READ = 3'b010,
    K_HV_ON   = 3'b011,
    K_HV_OFF  = 3'b100
  } fcp_kind_t;

  typedef struct packed {
    fcp_kind_t                 kind;
    logic [`FCP_ADDR_W-1:0]    addr;
    logic [`FCP_DATA_W-1:0]    data;
  } fcp_req_t;

  // hv flags ask the board to put high_voltage_level on that pin
  typedef struct packed {
    logic [`FCP_ADDR_W-1:0]    addr;
    logic [`FCP_DATA_W-1:0]    dout;
    logic                      dq_oe;
    logic                      ce_n;
    logic                      oe_n;
    logic                      we_n;
    logic                      a9_hv;
    logic                      oe_hv;
    logic                      ce_hv;
  } fcp_pins_t;

endpackage

// File: fcp_bus_cycle.sv
/*
  Cycle engine: runs one timed pin cycle on the flash (write, read, or one of
  the high-voltage patterns) per start pulse and answers with a done pulse.
  Assumes the caller holds req stable in the start cycle and starts nothing
  while a cycle runs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fcp_defines.svh"

module fcp_bus_cycle #(
  parameter int unsigned WP_CYC  = `FCP_WP_CYC,  // strobe low time
  parameter int unsigned ACC_CYC = `FCP_ACC_CYC, // read access time
  parameter int unsigned REC_CYC = `FCP_REC_CYC  // recovery after strobe
) (
  input  wire logic                   hclk,    // system clock
  input  wire logic                   hresetn, // async reset, active low
  input  wire logic                   clk_en,  // freezes all state when low
  input  wire logic                   start,   // run one cycle
  input  wire fcp_pkg::fcp_req_t      req,     // cycle description
  input  wire logic [`FCP_DATA_W-1:0] dq_in,   // flash data pins, sampled
  output var  fcp_pkg::fcp_pins_t     pins,    // flash pin drive
  output logic                        done,    // one-cycle end pulse
  output logic [`FCP_DATA_W-1:0]      rdata    // data of the last read
);

  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_PULSE = 2'b10,
    CY_REC   = 2'b11
  } fcp_cy_t;

  fcp_cy_t            state;
  fcp_pkg::fcp_kind_t kind_q;
  logic [7:0]         cnt;

  // decode of the latched cycle kind
  wire is_wr   = (kind_q == fcp_pkg::K_WRITE);
  wire is_rd   = (kind_q == fcp_pkg::K_READ) || (kind_q == fcp_pkg::K_HV_READ);
  wire is_on   = (kind_q == fcp_pkg::K_HV_ON);
  wire is_off  = (kind_q == fcp_pkg::K_HV_OFF);
  wire cnt_end = (cnt == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // address and data settle one cycle before any strobe falls, so the later
  // falling edge captures a stable address and the data outlive the rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= CY_IDLE;
      kind_q <= fcp_pkg::K_WRITE;
      cnt    <= 8'h00;
      done   <= 1'b0;
      rdata  <= 8'h00;
      pins   <= '{addr: '0, dout: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                  we_n: 1'b1, a9_hv: 1'b0, oe_hv: 1'b0, ce_hv: 1'b0};
    end else if (clk_en) begin
      done <= 1'b0;
      case (state)
        CY_IDLE: begin
          if (start) begin
            kind_q     <= req.kind;
            pins.addr  <= req.addr;
            pins.dout  <= req.data;
            pins.dq_oe <= (req.kind == fcp_pkg::K_WRITE);
            state      <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          pins.ce_n  <= is_off;                    // R09
          pins.we_n  <= !(is_wr || is_on || is_off); // R08
          pins.oe_n  <= !is_rd;                    // R14
          pins.a9_hv <= !is_wr && (kind_q != fcp_pkg::K_READ); // R10 R18
          pins.oe_hv <= is_on || is_off;           // R08
          pins.ce_hv <= is_off;                    // R09
          cnt        <= is_rd ? 8'(ACC_CYC - 1) : 8'(WP_CYC - 1); // R13
          state      <= CY_PULSE;
        end
        CY_PULSE: begin
          if (cnt_end) begin
            if (is_rd) begin
              rdata <= dq_in;
            end
            pins.ce_n  <= 1'b1;                    // R21
            pins.we_n  <= 1'b1;
            pins.oe_n  <= 1'b1;
            pins.a9_hv <= 1'b0;
            pins.oe_hv <= 1'b0;
            pins.ce_hv <= 1'b0;
            cnt        <= 8'(REC_CYC - 1);
            state      <= CY_REC;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        CY_REC: begin
          if (cnt_end) begin
            pins.dq_oe <= 1'b0;
            done       <= 1'b1;
            state      <= CY_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: state <= CY_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin pattern checks
  a_we_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    $fell(pins.we_n) |-> !pins.we_n [*3])
    else $error("write strobe shorter than three cycles");
  a_data_at_rise: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    ($rose(pins.we_n) && kind_q == fcp_pkg::K_WRITE) |-> pins.dq_oe && $stable(pins.dout))
    else $error("data not held at write strobe rise");
  a_write_inhibit: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    !pins.we_n |-> pins.oe_n)
    else $error("output enable low during a write strobe");
  a_hv_enable: assert property (@(posedge hclk) disable iff (!hresetn) // R08
    (pins.oe_hv && !pins.ce_hv) |-> pins.a9_hv && !pins.ce_n && !pins.we_n)
    else $error("protection enable pattern wrong");
  a_hv_disable: assert property (@(posedge hclk) disable iff (!hresetn) // R09
    pins.ce_hv |-> pins.a9_hv && pins.oe_hv && pins.ce_n && !pins.we_n)
    else $error("protection disable pattern wrong");
  a_hv_verify: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (pins.a9_hv && !pins.oe_n) |-> pins.we_n && !pins.ce_n && !pins.dq_oe)
    else $error("high voltage read pattern wrong");

endmodule

`default_nettype wire

// File: fcp_host_ctrl.sv
/*
  Flash command host: an AHB-Lite register slave that turns software orders
  into flash command sequences, high-voltage pin patterns and status polling.
  Assumes one flash on the pins, data inputs synchronous to hclk, and a board
  that turns the hv flags into high_voltage_level on those pins.
*/
// Contract
// R01: device shows poll bit and toggle bit
// R02: while busy, host only polls status
// R03: status valid from final strobe rise
// R04: busy poll bit inverted, true when done
// R05: toggle bit flips per read, starts 0
// R06: toggle stops when operation completes
// R07: device refuses writes to protected pages
// R08: protect on: hv nine and oe, ce/we low
// R09: protect off: same, ce at high voltage
// R10: hv check read: A1 high, A0 low
// R11: 90 unlock then read gives protect bit
// R12: no command clears hardwired protection
// R13: strobe glitches under 5 ns ignored
// R14: writes inhibited with oe low, ce/we high
// R15: program: AA, 55, A0, then address/data
// R16: page erase: six writes ending 30
// R17: chip erase: six writes ending 10 at 5555
// R18: id mode by 90 unlock or hv nine
// R19: id bytes selected by A1 and A0
// R20: software id mode ends only on F0
// R21: address at later fall, data earlier rise
// R22: page erase clears one 512-byte page
// R23: device floats its buses while busy
// R24: bad sequence write returns device to read
// R25: device ignores commands while busy
`timescale 1ns/100ps
`default_nettype none
`include "fcp_defines.svh"

module fcp_host_ctrl (
  input  wire logic                   hclk,        // system clock, 50 MHz
  input  wire logic                   hresetn,     // async reset, active low
  input  wire logic                   clk_en,      // freezes all state when low
  input  wire logic                   hsel,        // slave select
  input  wire logic [31:0]            haddr,       // byte address
  input  wire logic [1:0]             htrans,      // transfer type
  input  wire logic                   hwrite,      // write when high
  input  wire logic [2:0]             hsize,       // word only
  input  wire logic [31:0]            hwdata,      // write data
  input  wire logic                   hready,      // bus ready
  output logic                        hreadyout,   // always ready
  output logic [31:0]                 hrdata,      // read data
  output logic                        hresp,       // always okay
  output var  fcp_pkg::fcp_pins_t     flash_pins,  // flash pin drive
  input  wire logic [`FCP_DATA_W-1:0] flash_dq_in  // flash data pins
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_STEP  = 3'b001,
    S_WAIT  = 3'b010,
    S_POLL  = 3'b011,
    S_PWAIT = 3'b100
  } fcp_state_t;

  fcp_state_t             state;
  fcp_pkg::fcp_op_t       cur_op;
  logic [2:0]             step_idx;
  logic [`FCP_ADDR_W-1:0] addr_reg;
  logic [`FCP_DATA_W-1:0] wdata_reg;
  logic [`FCP_DATA_W-1:0] rdata_reg;
  logic                   st_done;
  logic                   st_refused;
  logic                   st_pollfail;
  logic                   id_mode;
  logic                   first_poll;
  logic                   prev_tog;
  logic                   cyc_start;
  logic                   wr_pend;
  logic [7:0]             wr_addr;
  logic                   cyc_done;
  logic [`FCP_DATA_W-1:0] cyc_rdata;
  fcp_pkg::fcp_req_t      step_req;
  logic [2:0]             last_idx;

  // command sequence table: one pin cycle per step index
  always_comb begin
    step_req = '{kind: fcp_pkg::K_WRITE, addr: `FCP_UNLOCK_A1, data: `FCP_CODE_AA}; // R15
    last_idx = 3'd0;
    case (cur_op)
      fcp_pkg::OP_READ:       step_req.kind = fcp_pkg::K_READ;
      fcp_pkg::OP_PROT_ON:    step_req.kind = fcp_pkg::K_HV_ON;   // R08
      fcp_pkg::OP_PROT_OFF:   step_req.kind = fcp_pkg::K_HV_OFF;  // R09
      fcp_pkg::OP_PROT_HWCHK: step_req = '{kind: fcp_pkg::K_HV_READ, addr: `FCP_PROT_ADDR, data: 8'h00}; // R10
      fcp_pkg::OP_HW_ID_READ: step_req.kind = fcp_pkg::K_HV_READ; // R18
      default: begin
        case (step_idx)
          3'd1: step_req = '{kind: fcp_pkg::K_WRITE, addr: `FCP_UNLOCK_A2, data: `FCP_CODE_55};
          3'd2: step_req.data = (cur_op == fcp_pkg::OP_PROGRAM) ? `FCP_CODE_PROG :
                                (cur_op == fcp_pkg::OP_RESET) ? `FCP_CODE_RESET :          // R20
                                (cur_op == fcp_pkg::OP_ID_ENTER ||
                                 cur_op == fcp_pkg::OP_PROT_SWCHK) ? `FCP_CODE_ID :        // R18
                                `FCP_CODE_ERASE;                                           // R16
          3'd3: if (cur_op == fcp_pkg::OP_PROT_SWCHK) begin
                  step_req = '{kind: fcp_pkg::K_READ, addr: `FCP_PROT_ADDR, data: 8'h00}; // R11
                end else if (cur_op == fcp_pkg::OP_PROGRAM) begin
                  step_req.addr = addr_reg;     // R15
                  step_req.data = wdata_reg;
                end
          3'd4: step_req = '{kind: fcp_pkg::K_WRITE, addr: `FCP_UNLOCK_A2, data: `FCP_CODE_55};
          3'd5: if (cur_op == fcp_pkg::OP_PAGE_ERASE) begin
                  step_req.addr = addr_reg;     // R16
                  step_req.data = `FCP_CODE_PAGE;
                end else begin
                  step_req.data = `FCP_CODE_CHIP; // R17
                end
          default: step_req.data = `FCP_CODE_AA;
        endcase
        last_idx = (cur_op == fcp_pkg::OP_ID_ENTER || cur_op == fcp_pkg::OP_RESET) ? 3'd2 :
                   (cur_op == fcp_pkg::OP_PROGRAM || cur_op == fcp_pkg::OP_PROT_SWCHK) ? 3'd3 : 3'd5;
      end
    endcase
    if (cur_op == fcp_pkg::OP_READ || cur_op == fcp_pkg::OP_HW_ID_READ) begin
      step_req.addr = addr_reg; // R19
    end
  end

  // decode and selection
  wire       in_poll   = (state == S_POLL) || (state == S_PWAIT);
  wire       is_busy   = (state != S_IDLE);
  wire       ahb_take  = hsel && htrans[1] && hready;
  wire       go        = wr_pend && (wr_addr == `FCP_REG_CTRL);
  wire       op_ok     = (hwdata[3:0] <= fcp_pkg::OP_HW_ID_READ);
  wire       st_clr    = wr_pend && (wr_addr == `FCP_REG_STATUS);
  wire       polls     = (cur_op == fcp_pkg::OP_PROGRAM) || (cur_op == fcp_pkg::OP_PAGE_ERASE) ||
                         (cur_op == fcp_pkg::OP_CHIP_ERASE);
  wire       expect7   = (cur_op == fcp_pkg::OP_PROGRAM) ? wdata_reg[`FCP_DQ_POLL] : 1'b1;
  wire       seq_end   = (state == S_WAIT) && cyc_done && (step_idx == last_idx) && !polls;
  wire       tog_stop  = (state == S_PWAIT) && cyc_done && !first_poll &&
                         (cyc_rdata[`FCP_DQ_TOGGLE] == prev_tog);          // R06
  wire       set_done  = seq_end || tog_stop;
  wire       set_refd  = go && (is_busy || !op_ok);                        // R02
  wire       set_pfail = tog_stop && (cyc_rdata[`FCP_DQ_POLL] != expect7); // R04
  wire       fcp_pkg::fcp_req_t cyc_req =
               in_poll ? fcp_pkg::fcp_req_t'{kind: fcp_pkg::K_READ, addr: addr_reg, data: 8'h00} : step_req; // R02
  wire [4:0] status    = {st_pollfail, id_mode, st_refused, st_done, is_busy};
  wire [31:0] rd_mux   = (haddr[7:0] == `FCP_REG_CTRL)   ? {28'h0, cur_op} :
                         (haddr[7:0] == `FCP_REG_ADDR)   ? {14'h0, addr_reg} :
                         (haddr[7:0] == `FCP_REG_WDATA)  ? {24'h0, wdata_reg} :
                         (haddr[7:0] == `FCP_REG_STATUS) ? {27'h0, status} :
                         (haddr[7:0] == `FCP_REG_RDATA)  ? {24'h0, rdata_reg} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else if (clk_en) begin
      wr_pend <= ahb_take && hwrite;
      wr_addr <= haddr[7:0];
      hrdata  <= (ahb_take && !hwrite) ? rd_mux : 32'h0;
    end
  end

  // software registers; sticky flags let a set win over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= '0;
      wdata_reg   <= '0;
      st_done     <= 1'b0;
      st_refused  <= 1'b0;
      st_pollfail <= 1'b0;
    end else if (clk_en) begin
      if (wr_pend && wr_addr == `FCP_REG_ADDR && !is_busy) begin
        addr_reg <= hwdata[`FCP_ADDR_W-1:0];
      end
      if (wr_pend && wr_addr == `FCP_REG_WDATA && !is_busy) begin
        wdata_reg <= hwdata[`FCP_DATA_W-1:0];
      end
      st_done     <= set_done  || (st_done     && !(st_clr && hwdata[`FCP_ST_DONE]));
      st_refused  <= set_refd  || (st_refused  && !(st_clr && hwdata[`FCP_ST_REFUSED]));
      st_pollfail <= set_pfail || (st_pollfail && !(st_clr && hwdata[`FCP_ST_POLLFAIL]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: steps through the table, then for program and erase polls the toggle bit until two
  // reads in a row agree; the host never reads the array meanwhile
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= S_IDLE;
      cur_op     <= fcp_pkg::OP_READ;
      step_idx   <= 3'd0;
      rdata_reg  <= '0;
      id_mode    <= 1'b0;
      first_poll <= 1'b0;
      prev_tog   <= 1'b0;
      cyc_start  <= 1'b0;
    end else if (clk_en) begin
      cyc_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go && op_ok) begin
            cur_op   <= fcp_pkg::fcp_op_t'(hwdata[3:0]);
            step_idx <= 3'd0;
            state    <= S_STEP;
          end
        end
        S_STEP: begin
          cyc_start <= 1'b1;
          state     <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            if (step_idx != last_idx) begin
              step_idx <= step_idx + 3'd1;
              state    <= S_STEP;
            end else if (polls) begin
              first_poll <= 1'b1; // R03
              state      <= S_POLL;
            end else begin
              if (cur_op == fcp_pkg::OP_ID_ENTER || cur_op == fcp_pkg::OP_PROT_SWCHK) begin
                id_mode <= 1'b1; // R18
              end else if (cur_op == fcp_pkg::OP_RESET) begin
                id_mode <= 1'b0; // R20
              end
              state <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          cyc_start <= 1'b1;
          state     <= S_PWAIT;
        end
        S_PWAIT: begin
          if (cyc_done) begin
            rdata_reg  <= cyc_rdata;
            prev_tog   <= cyc_rdata[`FCP_DQ_TOGGLE]; // R05
            first_poll <= 1'b0;
            state      <= tog_stop ? S_IDLE : S_POLL; // R06
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  fcp_bus_cycle u_cycle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .start   (cyc_start),
    .req     (cyc_req),
    .dq_in   (flash_dq_in),
    .pins    (flash_pins),
    .done    (cyc_done),
    .rdata   (cyc_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequence checks
  a_poll_reads_only: assert property (@(posedge hclk) disable iff (!hresetn) // R02
    (cyc_start && in_poll) |-> cyc_req.kind == fcp_pkg::K_READ && cyc_req.addr == addr_reg)
    else $error("non-read cycle while polling");
  a_unlock_first: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (cyc_start && !in_poll && step_idx == 3'd0 && cyc_req.kind == fcp_pkg::K_WRITE)
      |-> cyc_req.addr == `FCP_UNLOCK_A1 && cyc_req.data == `FCP_CODE_AA)
    else $error("first unlock write wrong");
  a_program_code: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (cyc_start && cur_op == fcp_pkg::OP_PROGRAM && step_idx == 3'd2) |-> cyc_req.data == `FCP_CODE_PROG)
    else $error("program code wrong");
  a_erase_last: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (cyc_start && !in_poll && step_idx == 3'd5) |->
      cyc_req.data == ((cur_op == fcp_pkg::OP_PAGE_ERASE) ? `FCP_CODE_PAGE : `FCP_CODE_CHIP))
    else $error("erase final code wrong");
  a_id_exit: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    $fell(id_mode) |-> $past(cur_op) == fcp_pkg::OP_RESET && $past(state) == S_WAIT)
    else $error("id mode left without reset command");

endmodule

`default_nettype wire

// File: fcp_flash_model.sv
/*
  Behavioural flash on the host's pins: command decoder, byte array, status
  polling, hardwired protection and identification.
  Assumes the host changes its pins just after hclk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module fcp_flash_model #(
  parameter logic [7:0] ID1   = 8'h3C, // arbitrary maker byte one
  parameter logic [7:0] ID2   = 8'h5A, // arbitrary maker byte two
  parameter logic [7:0] IDD   = 8'h66, // arbitrary device byte
  parameter int         NBUSY = 3      // polls answered while busy
) (
  input  wire logic               hclk, // sample clock
  input  wire fcp_pkg::fcp_pins_t p,    // host pin drive
  output logic [7:0]              dq    // data seen by host
);
  logic [7:0] mem [int];
  logic [7:0] tgt = 8'h00, last = 8'h00;
  logic [3:0] pv = 4'hF;
  logic       prot = 1'b0, id = 1'b0, tog = 1'b0;
  int         busy = 0, step = 0;
  // a write ends on the strobe rise; the hv patterns never count as writes
  wire        wr = p.we_n & !pv[3] & !pv[2] & pv[1] & !pv[0];
  wire [25:0] w  = {p.addr, p.dout};
  function automatic logic lk(int a);
    return prot && a[17:9] >= 9'd480;
  endfunction
  // released bus shows the inverse of the last byte, not a held value
  assign dq = (!p.ce_n && !p.oe_n) ? last : ~last;
  ////////////////////////////////////////
  always @(posedge hclk) begin
    pv <= {p.we_n, p.ce_n, p.oe_n, p.a9_hv};
    if (!p.we_n && p.a9_hv && p.oe_hv) prot <= !p.ce_hv;
    if (wr && busy == 0) begin
      case (step)
        0, 3: step <= (w == 26'h05555AA) ? step + 1 : 0;
        1, 4: step <= (w == 26'h02AAA55) ? step + 1 : 0;
        2: begin
          step <= (w[7:0] == 8'hA0) ? 10 : (w[7:0] == 8'h80) ? 3 : 0;
          if (w[7:0] == 8'h90) id <= 1'b1;
          if (w[7:0] == 8'hF0) id <= 1'b0;
        end
        5: begin
          step <= 0;
          foreach (mem[k]) if (!lk(k) && (w[7:0] == 8'h30 ? k[17:9] == p.addr[17:9] : w == 26'h0555510))
            mem[k] = 8'hFF;
          if (w[7:0] == 8'h30 || w[7:0] == 8'h10) begin tgt = 8'hFF; busy = NBUSY; tog = 1'b0; end
        end
        default: begin
          step <= 0;
          if (!lk(p.addr)) begin mem[p.addr] = p.dout; tgt = p.dout; busy = NBUSY; tog = 1'b0; end
        end
      endcase
    end
    if (pv[1] && !p.oe_n && !p.ce_n) begin
      if (busy > 0) begin
        last = {~tgt[7], tog, 6'h00};
        tog = !tog;
        busy--;
      end else if (p.a9_hv || id)
        last = (p.addr[1:0] == 2'b10) ? {7'h00, prot} : p.addr[0] ? (p.addr[1] ? ID2 : IDD) : ID1;
      else last = mem.exists(p.addr) ? mem[p.addr] : 8'hFF;
    end
  end
endmodule
`default_nettype wire

// File: fcp_host_ctrl_test.sv
/*
  Bench of the flash command host: AHB-Lite master tasks, a reference array
  and the flash model on the pins. Assumes the model's default id bytes.
*/
`timescale 1ns/100ps
`default_nettype none
module fcp_host_ctrl_test;
  logic               hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic [31:0]        haddr = '0, hwdata = '0, r;
  logic [1:0]         htrans = 2'b00;
  wire logic          hready, hresp;
  wire logic [31:0]   hrdata;
  fcp_pkg::fcp_pins_t pins;
  logic [7:0]         dq;
  logic [7:0]         emem [int];
  logic [7:0]         idt [4] = '{8'h3C, 8'h66, 8'h00, 8'h5A};
  int                 n_fail = 0, checks_done = 0, a, k;
  logic               eprot = 1'b0;
  always #10 hclk = ~hclk;
  fcp_host_ctrl uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .flash_pins(pins), .flash_dq_in(dq));
  fcp_flash_model fm (.hclk(hclk), .p(pins), .dq(dq));
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin n_fail++; $display("CHECK FAILED %s expected %h seen %h", s, exp, seen); end
  endtask
  // one single transfer; read data taken at the edge closing the data phase
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    haddr <= {24'h0, ad}; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 0);
  endtask
  // order an operation, poll busy under a bound, leave RDATA in r
  task automatic op(input logic [3:0] o, input int ad);
    int n;
    n = 0;
    ahb(1, 8'h04, ad); ahb(1, 8'h00, {28'h0, o});
    do begin ahb(0, 8'h0C, 0); n++; end while (r[0] !== 1'b0 && n < 3000);
    chk("busy", r[0], 0);
    ahb(0, 8'h10, 0);
  endtask
  function automatic logic [7:0] ev(int x);
    return emem.exists(x) ? emem[x] : 8'hFF;
  endfunction
  task automatic prog(input int x, input logic [7:0] v);
    ahb(1, 8'h08, {24'h0, v}); op(1, x);
    if (!(eprot && x[17:9] >= 480)) emem[x] = v;
    chk("poll data", r[7:0], ev(x));
    op(0, x); chk("readback", r[7:0], ev(x));
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin #2000000; n_fail++; give_verdict; end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hf7607a3e));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, 8'h40, 0); chk("unmapped", r, 0);
    for (k = 0; k < 4; k++) begin a = $urandom_range(32'h2FFFF); prog(a, 8'($urandom)); end
    // second order while the first runs is refused; the clear shows on the next status read
    ahb(1, 8'h00, 1); ahb(1, 8'h00, 0); op(0, a);
    ahb(0, 8'h0C, 0); chk("refused", r[2:1], 2'b11);
    ahb(1, 8'h0C, 32'h16); ahb(0, 8'h0C, 0); ahb(0, 8'h0C, 0); chk("cleared", r[2:1], 2'b00);
    op(2, a); chk("erase poll", r[7:0], 8'hFF);
    foreach (emem[x]) if (x[17:9] == a[17:9]) emem[x] = 8'hFF;
    foreach (emem[x]) begin op(0, x); chk("page erase", r[7:0], emem[x]); end
    op(6, 0); eprot = 1'b1; op(8, 0); chk("hv protect", r[0], 1);
    prog(32'h3FF00, 8'h12);
    ahb(0, 8'h0C, 0); chk("pollfail", r[4], 1);
    op(9, 0); chk("sw protect", r[0], 1);
    ahb(0, 8'h0C, 0); chk("id mode", r[3], 1);
    for (k = 0; k < 4; k++) begin op(0, k); chk("sw id", r[7:0], k == 2 ? {7'h0, eprot} : idt[k]); end
    op(5, 0); op(0, a); chk("after reset", r[7:0], ev(a));
    for (k = 0; k < 4; k++) begin op(10, k); chk("hv id", r[7:0], k == 2 ? {7'h0, eprot} : idt[k]); end
    op(7, 0); eprot = 1'b0; op(8, 0); chk("hv unprotect", r[0], 0);
    op(3, 0); emem.delete(); op(0, a); chk("chip erase", r[7:0], 8'hFF);
    ahb(1, 8'h00, 15); ahb(0, 8'h0C, 0); ahb(0, 8'h0C, 0); chk("bad op", r[2], 1);
    give_verdict;
  end
endmodule
`default_nettype wire
